// ### bench/ipm_bus_dev.sv
// two-wire bus with pull-ups
`timescale 1ns/100ps
module ipm_bus_dev (
  input wire logic sda_oe_n_i,
  input wire logic scl_oe_n_i,
  input wire logic scl_drv_i,
  input wire logic hold_i,
  output logic sda_o,
  output logic scl_o
);
  assign sda_o = sda_oe_n_i & ~hold_i;
  assign scl_o = scl_oe_n_i | scl_drv_i;
endmodule : ipm_bus_dev

// ### bench/ipm_top_bench.sv
// pin mode control bench
`timescale 1ns/100ps
module ipm_top_bench;
  logic clk_i = 0, nrst_i = 0, w = 0, r = 0, hs = 1, st = 0, hd = 0, lk = 0, hsd = 1;
  logic [1:0] lk_cnt = 2'h0;
  logic sda, scl, so, se, co, ce, hm;
  logic [3:0] a = 4'h0;
  logic [15:0] d = 16'h0000, q;
  int n_errors = 0, samples_checked = 0;
  always #10 clk_i = ~clk_i;
  // link-rate scl wish of the controller, 160 ns period, moved on clk_i edges only
  always @(posedge clk_i) begin
    if (lk) begin
      lk_cnt <= lk_cnt + 2'h1;
      if (lk_cnt == 2'h3) begin
        hs <= ~hs;
      end
    end
  end
  ipm_top DUT (.clk_i, .nrst_i, .addr_i(a), .wdata_i(d), .wr_i(w), .rd_i(r), .rdata_o(q),
    .hw_sda_i(hsd), .hw_scl_i(hs), .stretch_req_i(st), .sda_i(sda), .sda_o(so),
    .sda_oe_n_o(se), .scl_i(scl), .scl_o(co), .scl_oe_n_o(ce), .hsmode_o(hm));
  ipm_bus_dev bus (.sda_oe_n_i(se), .scl_oe_n_i(ce), .scl_drv_i(co), .hold_i(hd),
    .sda_o(sda), .scl_o(scl));
  task cmp(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (e !== g) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task wr(input logic [3:0] x, input logic [15:0] v);
    a <= x;
    d <= v;
    w <= 1'b1;
    @(posedge clk_i) w <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : wr
  task rd(input logic [3:0] x, input logic [15:0] e);
    a <= x;
    r <= 1'b1;
    @(posedge clk_i) r <= 1'b0;
    #1 cmp("rdata", e, q);
    @(posedge clk_i);
  endtask : rd
  task complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h0007);
    wr(4'h0, 16'h00ed);
    rd(4'h0, 16'h00ed);
    cmp("hsmode", 16'h0001, {15'h0, hm});
    rd(4'h4, 16'h0003);
    hd <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(4'h4, 16'h0002);
    hd <= 1'b0;
    wr(4'h0, 16'h0020);
    rd(4'h4, 16'h0000);
    st <= 1'b1;
    wr(4'h0, 16'h0000);
    rd(4'h4, 16'h0005);
    hsd <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(4'h4, 16'h0004);
    hsd <= 1'b1;
    wr(4'h0, 16'h0008);
    rd(4'h4, 16'h0007);
    st <= 1'b0;
    lk <= 1'b1;
    wr(4'h0, 16'h0004);
    cmp("scl_oe_n", 16'h0000, {15'h0, ce});
    cmp("scl_o", 16'h0000, {15'h0, co});
    repeat (2) @(posedge clk_i);
    lk <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp("scl_o", 16'h0001, {15'h0, co});
    cmp("scl_oe_n", 16'h0000, {15'h0, ce});
    rd(4'h8, 16'h0000);
    complete_run;
  end
endmodule : ipm_top_bench

// ### bench/ipm_top_chk.sv
// pin mode control checker
`timescale 1ns/100ps
module ipm_top_chk #(
  parameter int ADDR_W = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic sda_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic scl_oe_n_o,
  input wire logic hsmode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_wc; wr_i && addr_i == ADDR_W'(4'h0); endsequence
  sequence s_sw; wr_i && addr_i == ADDR_W'(4'h0) && wdata_i[5]; endsequence
  sequence s_st; rd_i && addr_i == ADDR_W'(4'h4); endsequence
  a_sda_low: assert property (s_sw ##0 !wdata_i[7] |-> ##2 !sda_oe_n_o) else $error("sda");
  a_sda_rel: assert property (s_sw ##0 wdata_i[7] |-> ##2 sda_oe_n_o) else $error("sda");
  a_scl_sw: assert property (s_sw |-> ##2 scl_oe_n_o == $past(wdata_i[6], 2))
    else $error("scl");
  a_hs_sel: assert property (s_wc |-> ##1 hsmode_o == $past(wdata_i[0]))
    else $error("hs");
  a_od_only: assert property (!sda_oe_n_o |-> !sda_o) else $error("od");
  a_rd_idle: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("idle");
  a_st_sda: assert property ($stable(sda_i) [*3] ##0 s_st |=> rdata_o[0] == $past(sda_i))
    else $error("sda st");
  a_st_scl: assert property ($stable(scl_i) [*3] ##0 s_st |=> rdata_o[1] == $past(scl_i))
    else $error("scl st");
endmodule : ipm_top_chk
bind ipm_top ipm_top_chk #(.ADDR_W(ADDR_W)) chk (.*);

// ### verilog/ipm_cfg.svh
// constants of the pin mode control block
`ifndef IPM_CFG_SVH
`define IPM_CFG_SVH
`define IPM_ADDR_W 4
`define IPM_CTRL_ADDR 4'h0
`define IPM_STAT_ADDR 4'h4
`define IPM_CTRL_RST 16'h0000
`define IPM_HSMODE_BIT 0
`define IPM_PPM_BIT 2
`define IPM_STRD_BIT 3
`define IPM_SWOE_BIT 5
`define IPM_SCLO_BIT 6
`define IPM_SDAO_BIT 7
`define IPM_CTRL_WMASK 16'h00ed
`define IPM_SDA_STAT_BIT 0
`define IPM_SCL_STAT_BIT 1
`define IPM_HW_DRV_BIT 2
`endif

// ### verilog/ipm_pad_drv.sv
// combinational pad drive selection
`timescale 1ns/100ps
module ipm_pad_drv
  import ipm_pkg::*;
(
  ipm_pin_if.drv p
);
  ipm_scl_mode_t mode;
  logic scl_lvl;
  logic sda_lvl;
  always_comb begin
    sda_lvl = p.sw_own ? p.sw_sda : p.hw_sda;
    scl_lvl = p.sw_own ? p.sw_scl : p.hw_scl;
    // stretching holds scl low under hardware ownership unless disabled
    if (!p.sw_own && p.stretch && !p.stretch_dis) begin
      scl_lvl = 1'b0;
    end
    if (p.ppm && !p.sw_own) begin
      mode = scl_lvl ? IPM_PP_HI : IPM_PP_LO;
    end else begin
      mode = IPM_OD;
    end
    p.sda_o = 1'b0;
    p.sda_oe_n = sda_lvl;
    case (mode)
      IPM_PP_HI: begin
        p.scl_o = 1'b1;
        p.scl_oe_n = 1'b0;
      end
      IPM_PP_LO: begin
        p.scl_o = 1'b0;
        p.scl_oe_n = 1'b0;
      end
      default: begin
        p.scl_o = 1'b0;
        p.scl_oe_n = scl_lvl;
      end
    endcase
  end
endmodule : ipm_pad_drv

// ### verilog/ipm_pin_if.sv
// pin request bundle between control and pad driver
`timescale 1ns/100ps
interface ipm_pin_if;
  logic sw_own;
  logic sw_sda;
  logic sw_scl;
  logic hw_sda;
  logic hw_scl;
  logic ppm;
  logic stretch;
  logic stretch_dis;
  logic sda_oe_n;
  logic sda_o;
  logic scl_oe_n;
  logic scl_o;
  modport ctl (output sw_own, sw_sda, sw_scl, hw_sda, hw_scl, ppm, stretch,
    stretch_dis, input sda_oe_n, sda_o, scl_oe_n, scl_o);
  modport drv (input sw_own, sw_sda, sw_scl, hw_sda, hw_scl, ppm, stretch,
    stretch_dis, output sda_oe_n, sda_o, scl_oe_n, scl_o);
endinterface : ipm_pin_if

// ### verilog/ipm_pkg.sv
// types of the pin mode control block
package ipm_pkg;
  typedef enum logic [1:0] {IPM_OD, IPM_PP_HI, IPM_PP_LO} ipm_scl_mode_t;
endpackage : ipm_pkg

// ### verilog/ipm_top.sv
// pin mode control registers and pin synchronisers
`timescale 1ns/100ps
`include "ipm_cfg.svh"
module ipm_top
  import ipm_pkg::*;
#(
  parameter int ADDR_W = `IPM_ADDR_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic hw_sda_i,
  input wire logic hw_scl_i,
  input wire logic stretch_req_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  output logic hsmode_o
);
  // status sits at byte offset four, so fewer address bits cannot reach it
  if (ADDR_W < 3) begin : g_addr_w_chk
    $error("ipm_top: ADDR_W too small");
  end
  // one address compare shared by the write and read decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [3:0] t);
    return a == ADDR_W'(t);
  endfunction : addr_hit
  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [15:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
  logic [1:0] sda_s_q, sda_s_d, scl_s_q, scl_s_d;
  logic sda_oe_n_q, sda_oe_n_d, scl_oe_n_q, scl_oe_n_d, scl_o_q, scl_o_d;
  logic sda_o_q, sda_o_d;
  ipm_pin_if pin ();
  always_comb begin
    ctrl_d = ctrl_q;
    // reserved bits are masked so they stay zero even if software slips
    if (wr_i && addr_hit(addr_i, `IPM_CTRL_ADDR)) begin
      ctrl_d = wdata_i & `IPM_CTRL_WMASK;
    end
    rdata_d = 16'h0000;
    if (rd_i && addr_hit(addr_i, `IPM_CTRL_ADDR)) begin
      rdata_d = ctrl_q;
    end else if (rd_i && addr_hit(addr_i, `IPM_STAT_ADDR)) begin
      rdata_d[`IPM_SDA_STAT_BIT] = sda_s_q[1];
      rdata_d[`IPM_SCL_STAT_BIT] = scl_s_q[1];
      rdata_d[`IPM_HW_DRV_BIT] = ~ctrl_q[`IPM_SWOE_BIT];
    end
    // first stage feeds only the second
    sda_s_d = {sda_s_q[0], sda_i};
    scl_s_d = {scl_s_q[0], scl_i};
    sda_oe_n_d = pin.sda_oe_n;
    scl_oe_n_d = pin.scl_oe_n;
    scl_o_d = pin.scl_o;
    sda_o_d = pin.sda_o;
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= `IPM_CTRL_RST;
      rdata_q <= 16'h0000;
      sda_s_q <= 2'h3;
      scl_s_q <= 2'h3;
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      sda_s_q <= sda_s_d;
      scl_s_q <= scl_s_d;
      sda_oe_n_q <= sda_oe_n_d;
      scl_oe_n_q <= scl_oe_n_d;
      scl_o_q <= scl_o_d;
      sda_o_q <= sda_o_d;
    end
  end
  // --------------------------------------------------------------
  // pad drive
  // --------------------------------------------------------------
  assign pin.sw_own = ctrl_q[`IPM_SWOE_BIT];
  assign pin.sw_sda = ctrl_q[`IPM_SDAO_BIT];
  assign pin.sw_scl = ctrl_q[`IPM_SCLO_BIT];
  assign pin.hw_sda = hw_sda_i;
  assign pin.hw_scl = hw_scl_i;
  assign pin.ppm = ctrl_q[`IPM_PPM_BIT];
  assign pin.stretch = stretch_req_i;
  assign pin.stretch_dis = ctrl_q[`IPM_STRD_BIT];
  ipm_pad_drv u_drv (
    .p(pin.drv)
  );
  assign rdata_o = rdata_q;
  assign sda_o = sda_o_q;
  assign sda_oe_n_o = sda_oe_n_q;
  assign scl_o = scl_o_q;
  assign scl_oe_n_o = scl_oe_n_q;
  assign hsmode_o = ctrl_q[`IPM_HSMODE_BIT];
endmodule : ipm_top
